/* pkg/seq_pkg.sv */
`default_nettype none
package seq_pkg;
    // ******************************************************************
    // Bus constants
    // ******************************************************************
    localparam logic [15:0] DUMMY_ADDR = 16'hffff;
    localparam logic [15:0] TRAP_VEC_HI = 16'hfffa;
    localparam logic [15:0] TRAP_VEC_LO = 16'hfffb;
    localparam logic [15:0] FETCH_OFS = 16'h0001;
    localparam logic [15:0] SEQ_NEXT_OFS = 16'h0002;
    localparam logic [7:0] SLEEP_ADDR_LO = 8'hff;
    // Idle levels of the irq, clear and hold pins, in that bit order
    localparam logic [2:0] PIN_IDLE = 3'h1;
    // ******************************************************************
    // Cycle counts and step numbers
    // ******************************************************************
    localparam logic [3:0] CYC_WAIT = 4'h9;
    localparam logic [3:0] CYC_TRAP = 4'hc;
    localparam logic [3:0] CYC_RET = 4'ha;
    localparam logic [3:0] CYC_DOZE = 4'h4;
    localparam logic [3:0] CYC_BRANCH = 4'h3;
    localparam logic [3:0] CYC_BSR = 4'h5;
    localparam logic [3:0] STEP_FETCH = 4'h1;
    localparam logic [3:0] STEP_DUMMY = 4'h2;
    localparam logic [3:0] STEP_PUSH0 = 4'h3;
    localparam logic [3:0] STEP_PUSH_END = 4'h9;
    localparam logic [3:0] STEP_POP_BASE = 4'h2;
    localparam logic [3:0] STEP_VEC_HI = 4'ha;
    localparam logic [3:0] STEP_VEC_LO = 4'hb;
    localparam logic [3:0] STEP_WAKE = 4'h3;
    localparam logic [3:0] STEP_BSR_END = 4'h4;
    localparam int POP_RET_HI = 5;
    // ******************************************************************
    // Types
    // ******************************************************************
    typedef enum logic [2:0] {
        halt_until_irq_instr,
        return_from_trap,
        software_trap_instr,
        doze_instr,
        rel_branch,
        branch_to_subroutine
    } instr_t;
    typedef enum logic [1:0] {st_idle, st_run, st_doze, st_hold} mode_t;
    typedef struct packed {
        logic [15:0] addr;
        logic rw;
        logic [7:0] dout;
        logic dout_oe_n;
    } bus_t;
endpackage : seq_pkg
`default_nettype wire

/* src/pin_sync.sv */
`default_nettype none
module pin_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [W-1:0] pin_async,
    output logic [W-1:0] pin_sync_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;
    sync_t r_reg;
    sync_t r_next;

    // ******************************************************************
    // Two-stage synchroniser, one chain per bit
    // ******************************************************************
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_comb begin
                r_next.s1[g] = pin_async[g];
                r_next.s2[g] = r_reg.s1[g];
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (srst) begin
            // Reset to the idle level so no false event follows reset
            r_reg <= {RST_VAL, RST_VAL};
        end else begin
            r_reg <= r_next;
        end
    end

    assign pin_sync_out = r_reg.s2;
endmodule : pin_sync
`default_nettype wire

/* src/cpu_trap_branch_sleep_sequencer.sv */
// Function
// - Wait: fetch op+1, read FFFF, push seven bytes downward, 9 cycles.
// - Trap: 12 cycles, push, read vector FFFA/FFFB, fetch routine.
// - Return: 10 cycles, dummy FFFF, pop sp+1..sp+7, fetch return.
// - Doze: 4 cycles, park on FFFF, data floats or shows address.
// - Branch: 3 cycles, offset, dummy FFFF, target or next opcode.
// - Subroutine branch: 5 cycles, push return low then high, fetch.
// - Doze stops the CPU clock and keeps all registers.
// - Peripheral clocks keep running during doze.
// - Doze ends only on interrupt request, clear input or hold input.
// - Hold input during doze goes straight to standby.
// - Accepted interrupt wakes and sets wake_to_irq; op+1 is still fetched, as for a masked one.
// - Masked interrupt wakes and continues after the doze opcode.
// - A request disabled at its source never wakes the CPU.
// - Hold input low resets the CPU and stops all clocks.
`default_nettype none
module cpu_trap_branch_sleep_sequencer
    import seq_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic start,
    input wire seq_pkg::instr_t instr,
    input wire logic [15:0] opcode_addr,
    input wire logic [15:0] stack_ptr,
    input wire logic [15:0] push_ret,
    input wire logic [15:0] push_index,
    input wire logic [7:0] push_acc_a,
    input wire logic [7:0] push_acc_b,
    input wire logic [7:0] push_ccr,
    input wire logic branch_taken,
    input wire logic [15:0] branch_target,
    input wire logic [7:0] rd_data,
    input wire logic muxed_bus_mode,
    input wire logic irq_masked,
    input wire logic irq_request,
    input wire logic chip_clear_input,
    input wire logic power_hold_input_n,
    output logic [15:0] addr,
    output logic rw,
    output logic [7:0] dout,
    output logic dout_oe_n,
    output logic busy,
    output logic done,
    output logic wake_to_irq,
    output logic sleeping,
    output logic standby,
    output logic cpu_reset,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic [15:0] trap_vector,
    output logic [55:0] popped
);
    import seq_pkg::*;

    typedef struct packed {
        mode_t mode;
        instr_t kind;
        logic [3:0] step;
        logic [15:0] op;
        logic [15:0] sp;
        bus_t bus;
        logic [7:0] vec_hi;
        logic [15:0] vec;
        logic [6:0][7:0] pop;
        logic done;
        logic to_irq;
        logic cpu_rst;
    } state_t;

    state_t r_reg;
    state_t r_next;
    logic [2:0] pins_s;
    logic irq_s;
    logic clear_s;
    logic hold_n_s;
    logic [55:0] push_bytes;

    // ******************************************************************
    // Pin synchronisers
    // ******************************************************************
    pin_sync #(.W(3), .RST_VAL(PIN_IDLE)) u_sync (
        .clk(clk),
        .srst(srst),
        .pin_async({irq_request, chip_clear_input, power_hold_input_n}),
        .pin_sync_out(pins_s)
    );
    assign irq_s = pins_s[2];
    assign clear_s = pins_s[1];
    assign hold_n_s = pins_s[0];

    assign push_bytes = {push_ccr, push_acc_b, push_acc_a, push_index[15:8],
        push_index[7:0], push_ret[15:8], push_ret[7:0]};

    // ******************************************************************
    // Decoding
    // ******************************************************************
    function automatic logic [3:0] last_step(input instr_t k);
        unique case (k)
            halt_until_irq_instr: last_step = CYC_WAIT;
            software_trap_instr: last_step = CYC_TRAP;
            return_from_trap: last_step = CYC_RET;
            doze_instr: last_step = CYC_DOZE;
            rel_branch: last_step = CYC_BRANCH;
            branch_to_subroutine: last_step = CYC_BSR;
            // Illegal codes end after the fetch instead of hanging
            default: last_step = STEP_FETCH;
        endcase
    endfunction : last_step

    function automatic bus_t bus_cycle(input instr_t k, input logic [3:0] s,
            input logic [15:0] op, input logic [15:0] sp,
            input logic [55:0] pb, input logic [7:0] hi,
            input logic [7:0] rd, input logic taken,
            input logic [15:0] target);
        bus_t b;
        logic [3:0] idx;
        b.addr = DUMMY_ADDR;
        b.rw = 1'b1;
        b.dout = 8'h00;
        b.dout_oe_n = 1'b1;
        idx = s - STEP_PUSH0;
        if (s == STEP_FETCH) begin
            b.addr = op + FETCH_OFS;
        end else if (s == STEP_DUMMY) begin
            b.addr = DUMMY_ADDR;
        end else if (((k == halt_until_irq_instr
                || k == software_trap_instr) && s <= STEP_PUSH_END)
                || (k == branch_to_subroutine && s <= STEP_BSR_END)) begin
            b.addr = sp - {12'h000, idx};
            b.rw = 1'b0;
            b.dout = pb[{idx[2:0], 3'b000} +: 8];
            b.dout_oe_n = 1'b0;
        end else begin
            unique case (k)
                software_trap_instr: begin
                    if (s == STEP_VEC_HI) begin
                        b.addr = TRAP_VEC_HI;
                    end else if (s == STEP_VEC_LO) begin
                        b.addr = TRAP_VEC_LO;
                    end else begin
                        b.addr = {hi, rd};
                    end
                end
                return_from_trap: begin
                    if (s < CYC_RET) begin
                        b.addr = sp + {12'h000, s - STEP_POP_BASE};
                    end else begin
                        b.addr = {hi, rd};
                    end
                end
                doze_instr: begin
                    b.addr = (s == STEP_WAKE) ? DUMMY_ADDR : op + FETCH_OFS;
                end
                rel_branch: begin
                    b.addr = taken ? target : op + SEQ_NEXT_OFS;
                end
                default: begin
                    b.addr = target;
                end
            endcase
        end
        return b;
    endfunction : bus_cycle

    // ******************************************************************
    // Sequencer
    // ******************************************************************
    always_comb begin
        logic [3:0] ns;
        ns = r_reg.step + 4'h1;
        r_next = r_reg;
        r_next.done = 1'b0;
        if (clear_s) begin
            r_next = '0;
            r_next.mode = st_idle;
            r_next.bus = {DUMMY_ADDR, 1'b1, 8'h00, 1'b1};
            r_next.cpu_rst = 1'b1;
        end else if (!hold_n_s) begin
            r_next.mode = st_hold;
            r_next.cpu_rst = 1'b1;
            r_next.bus = {DUMMY_ADDR, 1'b1, 8'h00, 1'b1};
        end else begin
            unique case (r_reg.mode)
                st_idle: begin
                    r_next.cpu_rst = 1'b0;
                    if (start) begin
                        r_next.mode = st_run;
                        r_next.kind = instr;
                        r_next.op = opcode_addr;
                        r_next.sp = stack_ptr;
                        r_next.to_irq = 1'b0;
                        r_next.step = STEP_FETCH;
                        r_next.bus = bus_cycle(instr, STEP_FETCH,
                            opcode_addr, stack_ptr, push_bytes, 8'h00,
                            rd_data, branch_taken, branch_target);
                    end
                end
                st_run: begin
                    if (r_reg.kind == return_from_trap
                            && r_reg.step >= STEP_PUSH0
                            && r_reg.step <= STEP_PUSH_END) begin
                        r_next.pop[r_reg.step - STEP_PUSH0] = rd_data;
                    end
                    if (r_reg.kind == software_trap_instr
                            && r_reg.step == STEP_VEC_HI) begin
                        r_next.vec_hi = rd_data;
                    end
                    if (r_reg.kind == software_trap_instr
                            && r_reg.step == STEP_VEC_LO) begin
                        r_next.vec = {r_reg.vec_hi, rd_data};
                    end
                    if (r_reg.step == last_step(r_reg.kind)) begin
                        r_next.mode = st_idle;
                        r_next.bus = {DUMMY_ADDR, 1'b1, 8'h00, 1'b1};
                    end else if (r_reg.kind == doze_instr
                            && r_reg.step == STEP_DUMMY) begin
                        r_next.mode = st_doze;
                        r_next.bus.addr = DUMMY_ADDR;
                        r_next.bus.rw = 1'b1;
                        r_next.bus.dout = SLEEP_ADDR_LO;
                        r_next.bus.dout_oe_n = !muxed_bus_mode;
                    end else begin
                        r_next.step = ns;
                        r_next.done = (ns == last_step(r_reg.kind));
                        r_next.bus = bus_cycle(r_reg.kind, ns, r_reg.op,
                            r_reg.sp, push_bytes,
                            (r_reg.kind == return_from_trap)
                                ? r_reg.pop[POP_RET_HI] : r_reg.vec_hi,
                            rd_data, branch_taken, branch_target);
                    end
                end
                st_doze: begin
                    if (irq_s) begin
                        r_next.mode = st_run;
                        r_next.to_irq = !irq_masked;
                        r_next.step = STEP_WAKE;
                        r_next.bus = {DUMMY_ADDR, 1'b1, 8'h00, 1'b1};
                    end
                end
                st_hold: begin
                    r_next.cpu_rst = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            r_reg <= '0;
            r_reg.mode <= st_idle;
            r_reg.bus <= {DUMMY_ADDR, 1'b1, 8'h00, 1'b1};
        end else begin
            r_reg <= r_next;
        end
    end

    // ******************************************************************
    // Outputs
    // ******************************************************************
    assign addr = r_reg.bus.addr;
    assign rw = r_reg.bus.rw;
    assign dout = r_reg.bus.dout;
    assign dout_oe_n = r_reg.bus.dout_oe_n;
    assign busy = (r_reg.mode != st_idle);
    assign done = r_reg.done;
    assign wake_to_irq = r_reg.to_irq;
    assign sleeping = (r_reg.mode == st_doze);
    assign standby = (r_reg.mode == st_hold);
    assign cpu_reset = r_reg.cpu_rst;
    assign cpu_clk_en = (r_reg.mode != st_doze && r_reg.mode != st_hold);
    assign periph_clk_en = (r_reg.mode != st_hold);
    assign trap_vector = r_reg.vec;
    assign popped = r_reg.pop;

    // ******************************************************************
    // Assertions
    // ******************************************************************
    logic seq_off;
    assign seq_off = srst || clear_s || !hold_n_s;
    sequence s_dummy_read;
        addr == DUMMY_ADDR && rw;
    endsequence
    sequence s_idle_start(instr_t k);
        start && r_reg.mode == st_idle && !clear_s && hold_n_s && instr == k;
    endsequence

    a_wait_length: assert property (
        @(posedge clk) disable iff (seq_off)
        s_idle_start(halt_until_irq_instr) |-> ##2 s_dummy_read
        ##1 !rw [*7] ##0 done)
        else $error("wait sequence length wrong");
    a_trap_vector: assert property (
        @(posedge clk) disable iff (seq_off)
        s_idle_start(software_trap_instr) |-> ##10
        (addr == TRAP_VEC_HI) ##1 (addr == TRAP_VEC_LO) ##1 done)
        else $error("trap vector reads wrong");
    a_ret_pop: assert property (
        @(posedge clk) disable iff (seq_off)
        s_idle_start(return_from_trap) |-> ##3
        (addr == $past(stack_ptr, 3) + 16'h0001 && rw) ##7 done)
        else $error("return pop sequence wrong");
    a_doze_park: assert property (
        @(posedge clk) disable iff (seq_off)
        s_idle_start(doze_instr) |-> ##2 s_dummy_read ##1
        (sleeping && addr == DUMMY_ADDR))
        else $error("doze does not park on dummy address");
    a_branch_target: assert property (
        @(posedge clk) disable iff (seq_off)
        s_idle_start(rel_branch) ##2 (s_dummy_read ##0 branch_taken)
        |=> (done && addr == $past(branch_target)))
        else $error("branch target fetch wrong");
    a_bsr_push: assert property (
        @(posedge clk) disable iff (seq_off)
        s_idle_start(branch_to_subroutine) |-> ##3
        (!rw && addr == $past(stack_ptr, 3)) ##1 !rw ##1 (rw && done))
        else $error("subroutine push wrong");
    a_doze_clocks: assert property (
        @(posedge clk) disable iff (srst)
        sleeping |-> !cpu_clk_en && periph_clk_en && $stable(popped))
        else $error("doze clocks or state wrong");
    a_doze_exit: assert property (
        @(posedge clk) disable iff (srst)
        sleeping ##1 !sleeping |-> $past(irq_s) || $past(clear_s)
        || !$past(hold_n_s))
        else $error("doze left without cause");
    a_hold_entry: assert property (
        @(posedge clk) disable iff (srst || clear_s)
        !hold_n_s |=> standby && cpu_reset && !periph_clk_en)
        else $error("hold input did not enter standby");
    a_wake_path: assert property (
        @(posedge clk) disable iff (seq_off)
        sleeping && irq_s |=> (wake_to_irq != $past(irq_masked)
        && addr == DUMMY_ADDR) ##1 (done && addr == r_reg.op + FETCH_OFS))
        else $error("wake path choice wrong");
endmodule : cpu_trap_branch_sleep_sequencer
`default_nettype wire

/* sim/bus_memory.sv */
`default_nettype none
module bus_memory (
    input wire logic clk,
    input wire logic [15:0] addr,
    input wire logic rw,
    input wire logic [7:0] dout,
    output logic [7:0] rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // ******************************************************************
    // Byte-wide memory with a fill pattern where nothing was written
    // ******************************************************************
    logic [7:0] mem [0:65535];
    logic [7:0] last = 8'h00;
    int i;
    initial begin
        for (i = 0; i < 65536; i++) begin
            mem[i] = i[15:8] ^ i[7:0] ^ 8'h3c;
        end
    end
    always @(posedge clk) begin
        if (rw === 1'b0) begin
            mem[addr] <= dout;
        end else begin
            last <= rd_data;
        end
    end
    // Not driven in write cycles: show the inverse of the last read byte
    assign rd_data = (rw === 1'b1) ? mem[addr] : ~last;
endmodule : bus_memory
`default_nettype wire

/* sim/cpu_trap_branch_sleep_sequencer_tb_top.sv */
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module cpu_trap_branch_sleep_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import seq_pkg::*;
    logic clk, srst, start, branch_taken, muxed_bus_mode, irq_masked;
    logic irq_request, chip_clear_input, power_hold_input_n;
    instr_t instr;
    logic [15:0] opcode_addr, stack_ptr, push_ret, push_index;
    logic [15:0] branch_target, addr, trap_vector, op;
    logic [7:0] push_acc_a, push_acc_b, push_ccr, rd_data, dout;
    logic rw, dout_oe_n, busy, done, wake_to_irq, sleeping, standby;
    logic cpu_reset, cpu_clk_en, periph_clk_en;
    logic [55:0] popped;
    typedef struct {int at; logic [15:0] a; logic w; logic [7:0] d;
        logic dn;} note_t;
    note_t q[$];
    note_t n;
    int cyc = 0, c0, checks = 0, n_fail = 0, t;
    logic [15:0] rnd = 16'h0022;
    // Trap vector expected to survive doze; a clear input zeroes it
    logic [15:0] vec_exp = 16'h3938;
    // ******************************************************************
    // Design and far side
    // ******************************************************************
    cpu_trap_branch_sleep_sequencer u_dut (.clk(clk), .srst(srst),
        .start(start), .instr(instr), .opcode_addr(opcode_addr),
        .stack_ptr(stack_ptr), .push_ret(push_ret),
        .push_index(push_index), .push_acc_a(push_acc_a),
        .push_acc_b(push_acc_b), .push_ccr(push_ccr),
        .branch_taken(branch_taken), .branch_target(branch_target),
        .rd_data(rd_data), .muxed_bus_mode(muxed_bus_mode),
        .irq_masked(irq_masked), .irq_request(irq_request),
        .chip_clear_input(chip_clear_input),
        .power_hold_input_n(power_hold_input_n), .addr(addr), .rw(rw),
        .dout(dout), .dout_oe_n(dout_oe_n), .busy(busy), .done(done),
        .wake_to_irq(wake_to_irq), .sleeping(sleeping),
        .standby(standby), .cpu_reset(cpu_reset),
        .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
        .trap_vector(trap_vector), .popped(popped));
    bus_memory u_mem (.clk(clk), .addr(addr), .rw(rw), .dout(dout),
        .rd_data(rd_data));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    // ******************************************************************
    // Result watcher: compares each bus cycle with its note
    // ******************************************************************
    always @(posedge clk) begin
        #5;
        while (q.size() > 0 && q[0].at <= cyc) begin
            n = q.pop_front();
            `CHK("addr", n.a, addr)
            `CHK("rw", n.w, rw)
            `CHK("done", n.dn, done)
            if (n.w == 1'b0) `CHK("dout", n.d, dout)
        end
    end
    // ******************************************************************
    // Helpers
    // ******************************************************************
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic newvals();
        rnd = lfsr(rnd);
        op = {1'b0, rnd[14:0]};
        rnd = lfsr(rnd);
        push_ret = rnd;
        rnd = lfsr(rnd);
        push_index = rnd;
        rnd = lfsr(rnd);
        {push_acc_a, push_acc_b} = rnd;
        rnd = lfsr(rnd);
        push_ccr = rnd[7:0];
        branch_target = {rnd[7:0], rnd[15:8]};
    endtask : newvals
    task automatic note(input int k, input logic [15:0] a, input logic w,
        input logic [7:0] d, input logic dn);
        q.push_back('{c0 + k, a, w, d, dn});
    endtask : note
    task automatic go(input instr_t i, input logic [15:0] sp);
        @(negedge clk);
        instr = i;
        opcode_addr = op;
        stack_ptr = sp;
        start = 1'b1;
        c0 = cyc;
        note(1, op + 16'h0001, 1'b1, 8'h00, 1'b0);
        note(2, 16'hffff, 1'b1, 8'h00, 1'b0);
        @(negedge clk);
        start = 1'b0;
    endtask : go
    task automatic pushes(input logic [15:0] sp);
        logic [7:0] b [7];
        int i;
        b = '{push_ret[7:0], push_ret[15:8], push_index[7:0],
            push_index[15:8], push_acc_a, push_acc_b, push_ccr};
        for (i = 0; i < 7; i++) begin
            note(3 + i, sp - 16'(i), 1'b0, b[i], 1'b0);
        end
    endtask : pushes
    task automatic finish_seq(input string nm);
        int k;
        for (k = 0; k < 60 && busy !== 1'b0; k++) @(negedge clk);
        `CHK("idle", 1'b0, busy)
        `CHK("notes left", 0, q.size())
        $display("test %s finished", nm);
    endtask : finish_seq
    task automatic clear_pulse();
        chip_clear_input = 1'b1;
        vec_exp = 16'h0000;
        repeat (4) @(negedge clk);
        `CHK("cpu reset", 1'b1, cpu_reset)
        `CHK("busy", 1'b0, busy)
        chip_clear_input = 1'b0;
        repeat (4) @(negedge clk);
        `CHK("standby", 1'b0, standby)
    endtask : clear_pulse
    task automatic doze(input logic mx, input logic msk, input int how);
        int k;
        newvals();
        muxed_bus_mode = mx;
        irq_masked = msk;
        go(doze_instr, 16'h0000);
        for (k = 0; k < 24; k++) @(negedge clk);
        `CHK("sleeping", 1'b1, sleeping)
        `CHK("cpu clk", 1'b0, cpu_clk_en)
        `CHK("periph clk", 1'b1, periph_clk_en)
        `CHK("kept", vec_exp, trap_vector)
        `CHK("park addr", 16'hffff, addr)
        `CHK("data oe_n", !mx, dout_oe_n)
        if (mx) `CHK("data", 8'hff, dout)
        if (how == 0) begin
            irq_request = 1'b1;
            for (k = 0; k < 10 && sleeping !== 1'b0; k++) @(negedge clk);
            irq_request = 1'b0;
            `CHK("wake addr", 16'hffff, addr)
            c0 = cyc;
            note(1, op + 16'h0001, 1'b1, 8'h00, 1'b1);
            finish_seq("doze wake");
            `CHK("irq wake", !msk, wake_to_irq)
        end else if (how == 1) begin
            power_hold_input_n = 1'b0;
            repeat (4) @(negedge clk);
            `CHK("standby", 1'b1, standby)
            `CHK("sleeping", 1'b0, sleeping)
            `CHK("periph clk", 1'b0, periph_clk_en)
            `CHK("cpu reset", 1'b1, cpu_reset)
            power_hold_input_n = 1'b1;
            clear_pulse();
        end else begin
            clear_pulse();
        end
        if (how != 0) $display("test doze exit %0d finished", how);
        q.delete();
    endtask : doze
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done
    // ******************************************************************
    // Tests
    // ******************************************************************
    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        $display("watchdog expired");
        test_done();
    end
    initial begin
        srst = 1'b1;
        start = 1'b0;
        instr = halt_until_irq_instr;
        {opcode_addr, stack_ptr, push_ret, push_index} = '0;
        {push_acc_a, push_acc_b, push_ccr, branch_target} = '0;
        {branch_taken, muxed_bus_mode, irq_masked, irq_request} = '0;
        chip_clear_input = 1'b0;
        power_hold_input_n = 1'b1;
        repeat (10) @(posedge clk);
        @(negedge clk);
        srst = 1'b0;
        newvals();
        go(halt_until_irq_instr, 16'h01ff);
        pushes(16'h01ff);
        q[$].dn = 1'b1;
        finish_seq("wait");
        newvals();
        go(software_trap_instr, 16'h01ff);
        pushes(16'h01ff);
        note(10, 16'hfffa, 1'b1, 8'h00, 1'b0);
        note(11, 16'hfffb, 1'b1, 8'h00, 1'b0);
        note(12, 16'h3938, 1'b1, 8'h00, 1'b1);
        finish_seq("trap");
        `CHK("vector", 16'h3938, trap_vector)
        go(return_from_trap, 16'h01f8);
        for (t = 3; t < 10; t++) note(t, 16'h01f6 + 16'(t), 1'b1, 8'h00, 1'b0);
        note(10, push_ret, 1'b1, 8'h00, 1'b1);
        finish_seq("return");
        `CHK("popped", {push_ret[7:0], push_ret[15:8], push_index[7:0],
            push_index[15:8], push_acc_a, push_acc_b, push_ccr},
            popped)
        for (t = 0; t < 2; t++) begin
            newvals();
            branch_taken = t[0];
            go(rel_branch, 16'h0000);
            note(3, t ? branch_target : op + 16'h0002, 1'b1, 8'h00, 1'b1);
            @(negedge clk);
            instr = halt_until_irq_instr;
            start = 1'b1;
            @(negedge clk);
            start = 1'b0;
            finish_seq("branch");
            `CHK("refused", c0 + 4, cyc)
        end
        newvals();
        go(branch_to_subroutine, 16'h0180);
        note(3, 16'h0180, 1'b0, push_ret[7:0], 1'b0);
        note(4, 16'h017f, 1'b0, push_ret[15:8], 1'b0);
        note(5, branch_target, 1'b1, 8'h00, 1'b1);
        finish_seq("subroutine");
        doze(1'b0, 1'b1, 0);
        doze(1'b1, 1'b0, 0);
        doze(1'b0, 1'b0, 1);
        doze(1'b1, 1'b1, 2);
        test_done();
    end
endmodule : cpu_trap_branch_sleep_sequencer_tb_top
`default_nettype wire
